// >>> nbc_host.sv
// Host side controller for a large-page flash bus: sequences strobe cycles.
// Assumes device pins are synchronous to clk and the caller waits for ack.
//
// Summary of operation
// - Rising write strobe latches command, address or data by latch selects.
// - Write inhibit held high when issuing program or erase codes.
// - Five address cycles, low byte first, upper bits zero in cycles two, five.
// - After load, read strobe pulses return successive bytes.
// - Cache read is 00h, five address cycles, then 31h.
// - Cache read start address has column zero.
// - Data out with write strobe high, latch selects low.
`include "nbc_consts.svh"

module nbc_host #(
  parameter int TW = 4
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Host request
  input  wire logic       req_valid,
  input  wire logic [2:0] req_op,
  input  wire logic [7:0] req_data,
  input  wire logic       req_last,
  output logic            req_ack,
  output logic [7:0]      rsp_data,
  output logic            busy_seen,
  output logic            in_cache_read,
  // Flash pins
  output logic            chip_enable_n,
  output logic            command_latch_select,
  output logic            address_latch_select,
  output logic            write_strobe_n,
  output logic            read_strobe_n,
  output logic            write_inhibit_n,
  output logic [7:0]      io_out,
  output logic            io_oe,
  input  wire logic [7:0] io_in,
  input  wire logic       ready_busy_n
);
  nbc_pkg::nbc_state_type st_r;
  nbc_pkg::nbc_op_type    op_r;
  logic [7:0]             byte_r;
  logic                   last_r;
  logic                   t_load;
  logic [TW-1:0]          t_val;
  logic                   t_exp;
  logic [2:0]             addr_cnt_r;

  nbc_phase_timer #(.W(TW)) u_timer (
    .clk      (clk),
    .resetn   (resetn),
    .load     (t_load),
    .load_val (t_val),
    .expired  (t_exp)
  );

  // ----------------------------------------------------------------
  // Strobe sequencer
  // ----------------------------------------------------------------
  // Timer runs down to zero inclusive, so an N-cycle phase loads N-1
  always_comb begin
    t_load = 1'b0;
    t_val  = TW'(`NBC_STROBE_LOW_CYC - 1);
    if (st_r == nbc_pkg::NBC_ST_IDLE && req_valid && !req_ack) begin
      t_load = (req_op != 3'(nbc_pkg::NBC_OP_IDLE));
    end else if (st_r == nbc_pkg::NBC_ST_LOW && t_exp) begin
      t_load = 1'b1;
      t_val  = TW'(`NBC_STROBE_HIGH_CYC - 1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r    <= nbc_pkg::NBC_ST_IDLE;
      op_r    <= nbc_pkg::NBC_OP_IDLE;
      byte_r  <= 8'h00;
      last_r  <= 1'b1;
      req_ack <= 1'b0;
    end else begin
      req_ack <= 1'b0;
      unique case (st_r)
        nbc_pkg::NBC_ST_IDLE: begin
          if (t_load) begin
            st_r   <= nbc_pkg::NBC_ST_LOW;
            op_r   <= nbc_pkg::nbc_op_type'(req_op);
            byte_r <= req_data;
            last_r <= req_last;
          end
        end
        nbc_pkg::NBC_ST_LOW: begin
          if (t_exp) begin
            st_r <= nbc_pkg::NBC_ST_HIGH;
          end
        end
        nbc_pkg::NBC_ST_HIGH: begin
          if (t_exp) begin
            st_r    <= nbc_pkg::NBC_ST_DONE;
            req_ack <= 1'b1;
          end
        end
        nbc_pkg::NBC_ST_DONE: begin
          st_r <= nbc_pkg::NBC_ST_IDLE;
        end
        default: begin
          st_r <= nbc_pkg::NBC_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic active;
  logic low_ph;
  assign active = (st_r == nbc_pkg::NBC_ST_LOW) || (st_r == nbc_pkg::NBC_ST_HIGH);
  assign low_ph = (st_r == nbc_pkg::NBC_ST_LOW);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chip_enable_n        <= 1'b1;
      command_latch_select <= 1'b0;
      address_latch_select <= 1'b0;
      write_strobe_n       <= 1'b1;
      read_strobe_n        <= 1'b1;
      io_out               <= 8'h00;
      io_oe                <= 1'b0;
    end else begin
      // Deselect between accesses only after the last of a sequence
      if (active) begin
        chip_enable_n <= 1'b0;
      end else if (st_r == nbc_pkg::NBC_ST_DONE && last_r) begin
        chip_enable_n <= 1'b1;
      end
      command_latch_select <= active && op_r == nbc_pkg::NBC_OP_CMD;
      address_latch_select <= active && op_r == nbc_pkg::NBC_OP_ADDR;
      write_strobe_n <= !(low_ph && op_r != nbc_pkg::NBC_OP_RDATA);
      read_strobe_n  <= !(low_ph && op_r == nbc_pkg::NBC_OP_RDATA);
      io_out <= byte_r;
      io_oe  <= active && op_r != nbc_pkg::NBC_OP_RDATA;
    end
  end

  // Sample read data at end of low phase, before the strobe rises
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp_data <= 8'h00;
    end else if (low_ph && t_exp && op_r == nbc_pkg::NBC_OP_RDATA) begin
      rsp_data <= io_in;
    end
  end

  // ----------------------------------------------------------------
  // Command tracking
  // ----------------------------------------------------------------
  logic cmd_edge;
  assign cmd_edge = (st_r == nbc_pkg::NBC_ST_HIGH) && t_exp && op_r == nbc_pkg::NBC_OP_CMD;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      write_inhibit_n <= 1'b0;
    end else if (st_r == nbc_pkg::NBC_ST_IDLE && t_load) begin
      // Enabled only for program/erase sequences; stays low otherwise
      write_inhibit_n <= (req_op == 3'(nbc_pkg::NBC_OP_CMD)) ?
        (req_data == `NBC_CMD_PROG_SETUP || req_data == `NBC_CMD_PROG_CONFIRM ||
         req_data == `NBC_CMD_ERASE_SETUP || req_data == `NBC_CMD_ERASE_CONFIRM ||
         req_data == 8'h15 || req_data == 8'h85) : write_inhibit_n;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_cnt_r <= 3'd0;
    end else if (cmd_edge) begin
      addr_cnt_r <= 3'd0;
    end else if ((st_r == nbc_pkg::NBC_ST_HIGH) && t_exp && op_r == nbc_pkg::NBC_OP_ADDR
                 && addr_cnt_r != `NBC_ADDR_CYCLES) begin
      addr_cnt_r <= addr_cnt_r + 3'd1;
    end
  end

  // Column bytes of the latest address run were all zero
  logic col_zero_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      col_zero_r <= 1'b1;
    end else if ((st_r == nbc_pkg::NBC_ST_HIGH) && t_exp && op_r == nbc_pkg::NBC_OP_ADDR
                 && addr_cnt_r < 3'd2) begin
      col_zero_r <= (byte_r == 8'h00) && (col_zero_r || addr_cnt_r == 3'd0);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_cache_read <= 1'b0;
    end else if (cmd_edge && byte_r == `NBC_CMD_CACHE_CONFIRM) begin
      in_cache_read <= 1'b1;
    end else if (cmd_edge && (byte_r == `NBC_CMD_CACHE_EXIT || byte_r == `NBC_CMD_RESET)) begin
      in_cache_read <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_seen <= 1'b0;
    end else begin
      busy_seen <= !ready_busy_n;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_cmd_ale_excl;
    @(posedge clk) disable iff (!resetn)
      !(command_latch_select && address_latch_select);
  endproperty
  a_cmd_ale_excl: assert property (p_cmd_ale_excl) else $error("both latch selects high");

  property p_strobes_excl;
    @(posedge clk) disable iff (!resetn)
      !(!write_strobe_n && !read_strobe_n);
  endproperty
  a_strobes_excl: assert property (p_strobes_excl) else $error("both strobes low");

  property p_ce_during_strobe;
    @(posedge clk) disable iff (!resetn)
      (!write_strobe_n || !read_strobe_n) |-> !chip_enable_n;
  endproperty
  a_ce_during_strobe: assert property (p_ce_during_strobe) else $error("strobe while deselected");

  property p_ws_pulse;
    @(posedge clk) disable iff (!resetn)
      $fell(write_strobe_n) |-> !write_strobe_n [*3] ##1 write_strobe_n;
  endproperty
  a_ws_pulse: assert property (p_ws_pulse) else $error("write strobe width wrong");

  property p_rs_no_latch;
    @(posedge clk) disable iff (!resetn)
      !read_strobe_n |-> !command_latch_select && !address_latch_select && write_strobe_n;
  endproperty
  a_rs_no_latch: assert property (p_rs_no_latch) else $error("read strobe with latch");

  property p_prog_wp;
    @(posedge clk) disable iff (!resetn)
      ($fell(write_strobe_n) && command_latch_select && io_out == `NBC_CMD_PROG_CONFIRM)
        |-> write_inhibit_n;
  endproperty
  a_prog_wp: assert property (p_prog_wp) else $error("program with inhibit low");

  property p_cache_col_zero;
    @(posedge clk) disable iff (!resetn)
      ($fell(write_strobe_n) && command_latch_select && io_out == `NBC_CMD_CACHE_CONFIRM)
        |-> col_zero_r;
  endproperty
  a_cache_col_zero: assert property (p_cache_col_zero) else $error("cache start column not zero");

  property p_addr_limit;
    @(posedge clk) disable iff (!resetn)
      addr_cnt_r <= `NBC_ADDR_CYCLES;
  endproperty
  a_addr_limit: assert property (p_addr_limit) else $error("address count overflow");

  property p_ack_pulse;
    @(posedge clk) disable iff (!resetn)
      req_ack |=> !req_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  c_cmd: cover property (@(posedge clk) disable iff (!resetn)
    $fell(write_strobe_n) && command_latch_select);
  c_addr: cover property (@(posedge clk) disable iff (!resetn)
    addr_cnt_r == `NBC_ADDR_CYCLES);
  c_read: cover property (@(posedge clk) disable iff (!resetn) $fell(read_strobe_n));
  c_cache: cover property (@(posedge clk) disable iff (!resetn) $rose(in_cache_read));
endmodule : nbc_host

// >>> nbc_consts.svh
// Constants for the flash bus host controller: command codes, timing, layout.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef NBC_CONSTS_SVH
`define NBC_CONSTS_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define NBC_CMD_READ_SETUP      8'h00
`define NBC_CMD_READ_CONFIRM    8'h30
`define NBC_CMD_CACHE_CONFIRM   8'h31
`define NBC_CMD_CACHE_EXIT      8'h34
`define NBC_CMD_RDO_SETUP       8'h05
`define NBC_CMD_RDO_CONFIRM     8'hE0
`define NBC_CMD_STATUS          8'h70
`define NBC_CMD_RESET           8'hFF
`define NBC_CMD_PROG_SETUP      8'h80
`define NBC_CMD_PROG_CONFIRM    8'h10
`define NBC_CMD_ERASE_SETUP     8'h60
`define NBC_CMD_ERASE_CONFIRM   8'hD0

// ----------------------------------------------------------------
// Address layout
// ----------------------------------------------------------------
`define NBC_COL_W               12
`define NBC_ROW_W               19
`define NBC_ADDR_CYCLES         3'd5
`define NBC_STATUS_DONE_BIT     5
`define NBC_STATUS_CACHE_BIT    6

// ----------------------------------------------------------------
// Timing: strobe phase lengths in ns and derived cycles (min, round up)
// ----------------------------------------------------------------
`define NBC_CLK_PERIOD_NS       8
`define NBC_STROBE_LOW_NS       24
`define NBC_STROBE_HIGH_NS      16
`define NBC_STROBE_LOW_CYC  ((`NBC_STROBE_LOW_NS + `NBC_CLK_PERIOD_NS - 1) / `NBC_CLK_PERIOD_NS)
`define NBC_STROBE_HIGH_CYC ((`NBC_STROBE_HIGH_NS + `NBC_CLK_PERIOD_NS - 1) / `NBC_CLK_PERIOD_NS)

`endif

// >>> nbc_pkg.sv
// Types for the flash bus host controller.
// Assumes nothing beyond a SystemVerilog compiler.
package nbc_pkg;
  // ----------------------------------------------------------------
  // Host request operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    NBC_OP_CMD    = 3'h0,
    NBC_OP_ADDR   = 3'h1,
    NBC_OP_WDATA  = 3'h2,
    NBC_OP_RDATA  = 3'h3,
    NBC_OP_IDLE   = 3'h4
  } nbc_op_type;

  // ----------------------------------------------------------------
  // Strobe sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    NBC_ST_IDLE = 4'b0001,
    NBC_ST_LOW  = 4'b0010,
    NBC_ST_HIGH = 4'b0100,
    NBC_ST_DONE = 4'b1000
  } nbc_state_type;
endpackage : nbc_pkg

// >>> nbc_phase_timer.sv
// Down counter that times one strobe phase.
// Assumes loads come only once expired; count holds at zero until the next load.
module nbc_phase_timer #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // Status
  output logic              expired
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  // Expiry must not depend on load: the host loads on expiry, a loop otherwise
  assign expired = (cnt_r == '0);
endmodule : nbc_phase_timer

// >>> nbc_flash_model.sv
// Behavioural flash device seen at the host controller's pins.
// Assumes pins come straight from the host; clk only times busy periods.
module nbc_flash_model #(
  parameter int PL = 20, // Page load cycles
  parameter int CL = 6,  // Cache latency cycles
  parameter int FT = 80  // Next page fetch cycles
) (
  // Timing
  input  wire logic        clk,
  // Flash pins
  input  wire logic        chip_enable_n,
  input  wire logic        command_latch_select,
  input  wire logic        address_latch_select,
  input  wire logic        write_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic [7:0]  io_out,
  output logic [7:0]       io_in,
  output logic             ready_busy_n,
  // Observation
  output logic [7:0]       last_cmd,
  output logic [11:0]      col,
  output logic [18:0]      row,
  output logic             cache
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] acnt;
  logic       stat_md;
  logic [7:0] dout;
  time        busy_end;
  time        fetch_end;
  initial begin
    acnt = 3'h5; stat_md = 0; dout = 8'h00; cache = 0; busy_end = 0; fetch_end = 0;
    col = '0; row = '0; last_cmd = 8'h00; ready_busy_n = 1;
  end
  // Pull-up level whenever no operation runs
  always @(posedge clk) ready_busy_n <= ($time >= busy_end);
  // Released bus shows the inverse of the last byte, never a stale match
  assign io_in = (!chip_enable_n && !read_strobe_n) ? dout : ~dout;
  always @(posedge write_strobe_n) begin
    if (!chip_enable_n && read_strobe_n) begin
      if (command_latch_select) begin
        // Busy refuses all but reset, status and cache exit
        if ($time >= busy_end || io_out == 8'hFF || io_out == 8'h70 || io_out == 8'h34) begin
          last_cmd <= io_out;
          acnt <= 3'h0;
          case (io_out)
            8'h30: begin busy_end <= $time + PL * 8; stat_md <= 0; end
            8'h31: begin
              cache <= 1; busy_end <= $time + CL * 8; fetch_end <= $time + FT * 8;
            end
            8'h34, 8'hFF: cache <= 0;
            8'h70: stat_md <= 1;
            8'h00, 8'hE0: stat_md <= 0;
            8'h7A, 8'h23, 8'h24, 8'h2A, 8'h2C: ;
            8'h80, 8'h10, 8'h85: ;
            8'h35, 8'h15, 8'h60, 8'hD0, 8'h90: ;
            default: ;
          endcase
        end
      end else if (address_latch_select && !(cache && last_cmd == 8'h05)) begin
        case (acnt)
          3'h0: col[7:0] <= io_out;
          3'h1: col[11:8] <= io_out[3:0];
          3'h2: row[7:0] <= io_out;
          3'h3: row[15:8] <= io_out;
          3'h4: row[18:16] <= io_out[2:0];
          default: ;
        endcase
        if (acnt != 3'h5) acnt <= acnt + 3'h1;
      end
    end
  end
  always @(negedge read_strobe_n) begin
    if (!chip_enable_n) begin
      dout <= stat_md ? {1'b0, $time >= busy_end, $time >= fetch_end, 5'h00}
                      : col[7:0] ^ row[7:0];
      if (!stat_md) col <= col + 12'h001;
    end
  end
endmodule : nbc_flash_model

// >>> tb_nbc_host.sv
// Self-checking bench for the flash host controller.
// Assumes the behavioural flash model sits on the pins.
`include "nbc_consts.svh"
module tb_nbc_host;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, resetn, req_valid, req_last, req_ack, busy_seen, in_cache_read;
  logic ce_n, cle, ale, we_n, re_n, wi_n, io_oe, rb_n, cache;
  logic [2:0] req_op;
  logic [7:0] req_data, rsp_data, io_out, io_in, last_cmd, q;
  logic [11:0] col;
  logic [18:0] row;
  int num_errors = 0;
  int n_checks = 0;
  typedef struct {logic [11:0] c; logic [18:0] r; logic [7:0] d0; logic [7:0] d1;} nbc_row_type;
  nbc_row_type rows [3] = '{'{12'h000, 19'h0_0012, 8'h12, 8'h13},
                            '{12'h123, 19'h7_FFFF, 8'hDC, 8'hDB},
                            '{12'h83E, 19'h4_0001, 8'h3F, 8'h3E}};
  nbc_host nbc_host_inst (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req_op(req_op),
    .req_data(req_data), .req_last(req_last), .req_ack(req_ack), .rsp_data(rsp_data),
    .busy_seen(busy_seen), .in_cache_read(in_cache_read), .chip_enable_n(ce_n),
    .command_latch_select(cle), .address_latch_select(ale), .write_strobe_n(we_n),
    .read_strobe_n(re_n), .write_inhibit_n(wi_n), .io_out(io_out), .io_oe(io_oe),
    .io_in(io_in), .ready_busy_n(rb_n));
  nbc_flash_model nbc_flash_model_inst (.clk(clk), .chip_enable_n(ce_n),
    .command_latch_select(cle), .address_latch_select(ale), .write_strobe_n(we_n),
    .read_strobe_n(re_n), .io_out(io_out), .io_in(io_in), .ready_busy_n(rb_n),
    .last_cmd(last_cmd), .col(col), .row(row), .cache(cache));
  always #4 clk = ~clk;
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // One host access; held until ack, dropped in the ack cycle
  task automatic acc(input logic [2:0] op, input logic [7:0] d, input logic last);
    int n;
    n = 0;
    @(posedge clk); #1;
    req_valid = 1; req_op = op; req_data = d; req_last = last;
    do begin @(posedge clk); #1; n++; end while (req_ack !== 1'b1 && n < 20);
    chk(32'(n), 32'd6);
    q = rsp_data;
    req_valid = 0; req_last = 0; req_op = nbc_pkg::NBC_OP_IDLE;
  endtask : acc
  task automatic addr5(input logic [11:0] c, input logic [18:0] r);
    logic [39:0] a;
    a = {5'h00, r, 4'h0, c}; // Upper bits of cycles two and five stay low
    for (int k = 0; k < 5; k++) acc(nbc_pkg::NBC_OP_ADDR, a[8*k +: 8], 0);
  endtask : addr5
  task automatic wait_ready();
    int n;
    logic seen;
    n = 0; seen = 0;
    while (n < 300 && !(seen && busy_seen === 1'b0)) begin
      @(posedge clk); #1; n++;
      if (busy_seen === 1'b1) seen = 1;
    end
    chk(32'(seen), 32'd1);
  endtask : wait_ready
  initial begin
    #50000;
    num_errors++;
    summarize();
  end
  initial begin
    clk = 0; resetn = 0; req_valid = 0; req_last = 0; req_data = 8'h00;
    req_op = nbc_pkg::NBC_OP_IDLE;
    repeat (6) @(posedge clk);
    #1;
    chk({ce_n, wi_n, io_oe, we_n, re_n}, 32'h0000_0013);
    resetn = 1;
    // Ordinary reads; later rows skip the setup code
    for (int i = 0; i < 3; i++) begin
      if (i == 0) acc(nbc_pkg::NBC_OP_CMD, `NBC_CMD_READ_SETUP, 0);
      addr5(rows[i].c, rows[i].r);
      acc(nbc_pkg::NBC_OP_CMD, `NBC_CMD_READ_CONFIRM, 0);
      chk({col, 1'b0, row}, {rows[i].c, 1'b0, rows[i].r});
      wait_ready();
      acc(nbc_pkg::NBC_OP_RDATA, 8'h00, 0);
      chk(q, rows[i].d0);
      acc(nbc_pkg::NBC_OP_RDATA, 8'h00, 0);
      chk(q, rows[i].d1);
    end
    // Random output inside the last page
    acc(nbc_pkg::NBC_OP_CMD, `NBC_CMD_RDO_SETUP, 0);
    acc(nbc_pkg::NBC_OP_ADDR, 8'h10, 0);
    acc(nbc_pkg::NBC_OP_ADDR, 8'h00, 0);
    acc(nbc_pkg::NBC_OP_CMD, `NBC_CMD_RDO_CONFIRM, 0);
    acc(nbc_pkg::NBC_OP_RDATA, 8'h00, 1);
    chk(q, 8'h11);
    @(posedge clk);
    #1;
    chk({ce_n, io_oe}, 32'h2);
    // Cache read from column zero
    acc(nbc_pkg::NBC_OP_CMD, `NBC_CMD_READ_SETUP, 0);
    addr5(12'h000, 19'h0_0005);
    acc(nbc_pkg::NBC_OP_CMD, `NBC_CMD_CACHE_CONFIRM, 0);
    chk({in_cache_read, cache}, 32'h3);
    wait_ready();
    acc(nbc_pkg::NBC_OP_CMD, 8'h99, 0);
    chk(in_cache_read, 32'h1);
    acc(nbc_pkg::NBC_OP_CMD, `NBC_CMD_STATUS, 0);
    acc(nbc_pkg::NBC_OP_RDATA, 8'h00, 0);
    chk(q, 32'h40);
    acc(nbc_pkg::NBC_OP_CMD, `NBC_CMD_READ_SETUP, 0);
    acc(nbc_pkg::NBC_OP_RDATA, 8'h00, 0);
    chk(q, 32'h05);
    acc(nbc_pkg::NBC_OP_CMD, `NBC_CMD_CACHE_EXIT, 1);
    @(posedge clk);
    #1;
    chk({in_cache_read, cache, ce_n, io_oe}, 32'h2);
    // Erase code must lift the inhibit line
    acc(nbc_pkg::NBC_OP_CMD, `NBC_CMD_ERASE_SETUP, 1);
    chk({wi_n, last_cmd}, {1'b1, 8'h60});
    // Program pair keeps the inhibit line lifted through the confirm
    acc(nbc_pkg::NBC_OP_CMD, `NBC_CMD_PROG_SETUP, 0);
    acc(nbc_pkg::NBC_OP_CMD, `NBC_CMD_PROG_CONFIRM, 1);
    chk({wi_n, last_cmd}, {1'b1, 8'h10});
    summarize();
  end
endmodule : tb_nbc_host
